// ---- verilog/scp_map.svh ----
// Offsets, field positions, reset values and timing counts of the clock control block.
// Behaviour
// - Fuse 10 or 01 selects RC oscillator.
// - Slower RC mode is RC divided by two.
// - Fuse 11 selects low-power oscillator.
// - Reset copies matching factory trim byte.
// - Watchdog oscillator still times reset delay.
// - Wake waits 6 cycles; reset adds fused delay.
// - Reset pin fuse stretches shortest delay.
// - Delivered fuses give RC, long start, divide-eight.
// - CPU, I/O, ADC, flash clocks divided alike.
// - Divider switch has no glitch, no overspeed.
// - Switch: old period, then new periods.
// - Trim is monotonic seven bits; top reads zero.
// - Unlock sets only when other bits zero.
// - Unlock clears after four cycles or use.
// - Division accepted only inside unlock window.
// - Division resets to 0000 or 0011 by fuse.
// - Any division value accepted through unlock.
// - Codes 0000..0011 divide 1,2,4,8; 6:4 zero.
// - Codes 0100..1000 divide 16..256; rest reserved.
`ifndef SCP_MAP_SVH
`define SCP_MAP_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define SCP_ADDR_W             2
`define SCP_OFF_TRIM           2'h0
`define SCP_OFF_PRESCALE       2'h1
`define SCP_OFF_STATUS         2'h2

// ----------------------------------------------------------------------------
// Field positions and values
// ----------------------------------------------------------------------------
`define SCP_UNLOCK_BIT         7
`define SCP_UNLOCK_WORD        8'h80
`define SCP_TRIM_MSB           6
`define SCP_DIV_MSB            3
`define SCP_DIV_MAX_EXP        4'h8
`define SCP_DIV_RST_FAST       4'h0
`define SCP_DIV_RST_SLOW       4'h3
`define SCP_FUSE_RC_FAST       2'h2
`define SCP_FUSE_RC_SLOW       2'h1
`define SCP_FUSE_LOW_POWER     2'h3
`define SCP_SUT_SHORT          2'h0
`define SCP_SUT_MEDIUM         2'h1
`define SCP_SUT_LONG           2'h2

// ----------------------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------------------
`define SCP_UNLOCK_CYCLES      3'h4
`define SCP_WAKE_CK            4'h6
`define SCP_RESET_CK           4'he
`define SCP_DELAY_SHORT_MS     4
`define SCP_DELAY_SHORT_WDT    512
`define SCP_DELAY_LONG_MS      64
`define SCP_DELAY_LONG_WDT     8192

`endif

// ---- verilog/scp_pkg.sv ----
// Types shared by the clock control block.
package scp_pkg;
   typedef enum logic [2:0] {
      SCP_ST_RESET_CK,
      SCP_ST_RESET_WDT,
      SCP_ST_RUN,
      SCP_ST_SLEEP,
      SCP_ST_WAKE
   } scp_state_t;

   typedef enum logic [1:0] {
      SCP_SRC_RC_FAST,
      SCP_SRC_RC_SLOW,
      SCP_SRC_LOW_POWER
   } scp_source_t;
endpackage

// ---- verilog/scp_trim_rom.sv ----
// Factory trim store: one byte per RC mode, read data registered.
`timescale 1ns/1ps
module scp_trim_rom #(
   parameter logic [6:0] TRIM_FAST = 7'h40,
   parameter logic [6:0] TRIM_SLOW = 7'h40
) (
   input  wire logic       clock_i,
   input  wire logic       slow_sel_i,
   output logic [6:0]      trim_o
);
   logic [6:0] rom_q [2];

   // Contents are fixed at build time; the array keeps the lookup in one place.
   always_comb begin
      rom_q[0] = TRIM_FAST;
      rom_q[1] = TRIM_SLOW;
   end

   always_ff @(posedge clock_i) begin
      trim_o <= rom_q[slow_sel_i];
   end
endmodule

// ---- verilog/scp_top.sv ----
// Clock source selection, start-up timing, trim register and glitch-free prescaler.
//
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`include "scp_map.svh"
module scp_top
   import scp_pkg::*;
#(
   parameter int         DELAY_SHORT_WDT = `SCP_DELAY_SHORT_WDT,
   parameter int         DELAY_LONG_WDT  = `SCP_DELAY_LONG_WDT,
   parameter logic [6:0] TRIM_FAST       = 7'h40,
   parameter logic [6:0] TRIM_SLOW       = 7'h40
) (
   input  wire logic                   clock_i,
   input  wire logic                   rst_i,
   input  wire logic [1:0]             clock_source_select_fuse_i,
   input  wire logic [1:0]             startup_time_fuse_i,
   input  wire logic                   divide_by_eight_fuse_i,
   input  wire logic                   reset_pin_disable_fuse_i,
   input  wire logic                   lp_osc_tick_i,
   input  wire logic                   wdt_osc_tick_i,
   input  wire logic                   sleep_i,
   input  wire logic                   wake_i,
   input  wire logic [`SCP_ADDR_W-1:0] addr_i,
   input  wire logic [7:0]             wdata_i,
   input  wire logic                   write_i,
   input  wire logic                   read_i,
   output logic      [7:0]             rdata_o,
   output logic      [6:0]             osc_trim_o,
   output logic                        cpu_clk_en_o,
   output logic                        io_clk_en_o,
   output logic                        adc_clk_en_o,
   output logic                        flash_clk_en_o,
   output logic                        wdt_clk_en_o,
   output logic                        running_o
);

   localparam int WDT_CNT_W = $clog2(DELAY_LONG_WDT + 1);

   // ----------------------------------------------------------------------------
   // Fuse capture
   // ----------------------------------------------------------------------------
   scp_source_t source_q;
   logic [1:0]  startup_q;
   logic        rst_pin_dis_q;

   // Fuses use the convention that 0 means programmed.
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         startup_q     <= startup_time_fuse_i;
         rst_pin_dis_q <= ~reset_pin_disable_fuse_i;
         case (clock_source_select_fuse_i)
            `SCP_FUSE_RC_SLOW:   source_q <= SCP_SRC_RC_SLOW;
            `SCP_FUSE_LOW_POWER: source_q <= SCP_SRC_LOW_POWER;
            default:             source_q <= SCP_SRC_RC_FAST;
         endcase
      end
   end

   // ----------------------------------------------------------------------------
   // Source clock ticks
   // ----------------------------------------------------------------------------
   logic half_q;
   logic src_tick;

   // The slow RC mode is the fast oscillator behind one divide-by-two stage.
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         half_q <= 1'b0;
      end else begin
         half_q <= ~half_q;
      end
   end

   always_comb begin
      case (source_q)
         SCP_SRC_RC_SLOW:   src_tick = half_q;
         SCP_SRC_LOW_POWER: src_tick = lp_osc_tick_i;
         default:           src_tick = 1'b1;
      endcase
   end

   // The watchdog oscillator runs on its own, whatever the system clock source is.
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         wdt_clk_en_o <= 1'b0;
      end else begin
         wdt_clk_en_o <= wdt_osc_tick_i;
      end
   end

   // ----------------------------------------------------------------------------
   // Trim register
   // ----------------------------------------------------------------------------
   logic [6:0] factory_trim;
   logic       trim_we;

   scp_trim_rom #(
      .TRIM_FAST (TRIM_FAST),
      .TRIM_SLOW (TRIM_SLOW)
   ) u_rom (
      .clock_i    (clock_i),
      .slow_sel_i (clock_source_select_fuse_i == `SCP_FUSE_RC_SLOW),
      .trim_o     (factory_trim)
   );

   assign trim_we = write_i && (addr_i == `SCP_OFF_TRIM);

   // Reset is held for at least two edges, so the registered store output is valid.
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         osc_trim_o <= factory_trim;
      end else if (trim_we) begin
         osc_trim_o <= wdata_i[`SCP_TRIM_MSB:0];
      end
   end

   // ----------------------------------------------------------------------------
   // Prescale register and unlock window
   // ----------------------------------------------------------------------------
   logic       pre_we;
   logic [2:0] unlock_cnt_q;
   logic       unlock;
   logic       div_accept;
   logic [3:0] div_sel_q;

   assign pre_we     = write_i && (addr_i == `SCP_OFF_PRESCALE);
   assign unlock     = (unlock_cnt_q != 3'h0);
   assign div_accept = pre_we && unlock && !wdata_i[`SCP_UNLOCK_BIT];

   // A rewrite of the unlock word inside the window is ignored entirely.
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         unlock_cnt_q <= 3'h0;
      end else if (pre_we && (wdata_i == `SCP_UNLOCK_WORD) && !unlock) begin
         unlock_cnt_q <= `SCP_UNLOCK_CYCLES;
      end else if (div_accept) begin
         unlock_cnt_q <= 3'h0;
      end else if (unlock) begin
         unlock_cnt_q <= unlock_cnt_q - 3'h1;
      end
   end

   // Reserved codes are stored as written and divide like the largest factor.
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         if (divide_by_eight_fuse_i) begin
            div_sel_q <= `SCP_DIV_RST_FAST;
         end else begin
            div_sel_q <= `SCP_DIV_RST_SLOW;
         end
      end else if (div_accept) begin
         div_sel_q <= wdata_i[`SCP_DIV_MSB:0];
      end
   end

   // ----------------------------------------------------------------------------
   // Start-up sequencer
   // ----------------------------------------------------------------------------
   scp_state_t             state_q;
   logic [3:0]             ck_cnt_q;
   logic [WDT_CNT_W-1:0]   wdt_cnt_q;
   logic [WDT_CNT_W-1:0]   wdt_target;

   always_comb begin
      case (startup_q)
         `SCP_SUT_SHORT:  wdt_target = rst_pin_dis_q ?
                             WDT_CNT_W'(DELAY_SHORT_WDT) : '0;
         `SCP_SUT_MEDIUM: wdt_target = WDT_CNT_W'(DELAY_SHORT_WDT);
         `SCP_SUT_LONG:   wdt_target = WDT_CNT_W'(DELAY_LONG_WDT);
         default:         wdt_target = WDT_CNT_W'(DELAY_LONG_WDT);
      endcase
   end

   // The real-time part is counted on watchdog oscillator ticks, not on the source.
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         state_q   <= SCP_ST_RESET_CK;
         ck_cnt_q  <= 4'h0;
         wdt_cnt_q <= '0;
      end else begin
         case (state_q)
            SCP_ST_RESET_CK: begin
               if (src_tick) begin
                  if (ck_cnt_q == `SCP_RESET_CK - 4'h1) begin
                     ck_cnt_q <= 4'h0;
                     if (wdt_target == '0) begin
                        state_q <= SCP_ST_RUN;
                     end else begin
                        state_q <= SCP_ST_RESET_WDT;
                     end
                  end else begin
                     ck_cnt_q <= ck_cnt_q + 4'h1;
                  end
               end
            end
            SCP_ST_RESET_WDT: begin
               if (wdt_osc_tick_i) begin
                  if (wdt_cnt_q == wdt_target - WDT_CNT_W'(1)) begin
                     wdt_cnt_q <= '0;
                     state_q   <= SCP_ST_RUN;
                  end else begin
                     wdt_cnt_q <= wdt_cnt_q + WDT_CNT_W'(1);
                  end
               end
            end
            SCP_ST_RUN: begin
               if (sleep_i) begin
                  state_q <= SCP_ST_SLEEP;
               end
            end
            SCP_ST_SLEEP: begin
               if (wake_i) begin
                  ck_cnt_q <= 4'h0;
                  state_q  <= SCP_ST_WAKE;
               end
            end
            SCP_ST_WAKE: begin
               if (src_tick) begin
                  if (ck_cnt_q == `SCP_WAKE_CK - 4'h1) begin
                     ck_cnt_q <= 4'h0;
                     state_q  <= SCP_ST_RUN;
                  end else begin
                     ck_cnt_q <= ck_cnt_q + 4'h1;
                  end
               end
            end
            default: begin
               state_q <= SCP_ST_RESET_CK;
            end
         endcase
      end
   end

   assign running_o = (state_q == SCP_ST_RUN);

   // ----------------------------------------------------------------------------
   // Glitch-free prescaler
   // ----------------------------------------------------------------------------
   logic [3:0] act_exp_q;
   logic [3:0] req_exp;
   logic [7:0] pre_cnt_q;
   logic [7:0] pre_last;
   logic       period_end;

   always_comb begin
      if (div_sel_q > `SCP_DIV_MAX_EXP) begin
         req_exp = `SCP_DIV_MAX_EXP;
      end else begin
         req_exp = div_sel_q;
      end
   end

   // Factor is two to the power of the code: 1 up to 256 source ticks per output.
   assign pre_last   = 8'((9'h1 << act_exp_q) - 9'h1);
   assign period_end = src_tick && (pre_cnt_q == pre_last);

   // A new factor is only taken when the current period completes, so the
   // old period always finishes whole and no shortened pulse appears.
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         if (divide_by_eight_fuse_i) begin
            act_exp_q <= `SCP_DIV_RST_FAST;
         end else begin
            act_exp_q <= `SCP_DIV_RST_SLOW;
         end
         pre_cnt_q <= 8'h0;
      end else if (period_end) begin
         act_exp_q <= req_exp;
         pre_cnt_q <= 8'h0;
      end else if (src_tick) begin
         pre_cnt_q <= pre_cnt_q + 8'h1;
      end
   end

   // All four domains share one enable, whichever source feeds the counter.
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         cpu_clk_en_o   <= 1'b0;
         io_clk_en_o    <= 1'b0;
         adc_clk_en_o   <= 1'b0;
         flash_clk_en_o <= 1'b0;
      end else begin
         cpu_clk_en_o   <= period_end && running_o;
         io_clk_en_o    <= period_end && running_o;
         adc_clk_en_o   <= period_end && running_o;
         flash_clk_en_o <= period_end && running_o;
      end
   end

   // ----------------------------------------------------------------------------
   // Register read port
   // ----------------------------------------------------------------------------
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         rdata_o <= 8'h0;
      end else if (read_i) begin
         case (addr_i)
            `SCP_OFF_TRIM:     rdata_o <= {1'b0, osc_trim_o};
            `SCP_OFF_PRESCALE: rdata_o <= {unlock, 3'h0, div_sel_q};
            `SCP_OFF_STATUS:   rdata_o <= {3'h0, running_o, act_exp_q[3:0]};
            default:           rdata_o <= 8'h0;
         endcase
      end else begin
         rdata_o <= 8'h0;
      end
   end

endmodule

// ---- verif/scp_top_sva.sv ----
// Port checker for the clock control block.
`timescale 1ns/1ps
`include "scp_map.svh"
module scp_top_sva #(
   parameter int DELAY_SHORT_WDT = 4,
   parameter int DELAY_LONG_WDT  = 8
) (
   input wire logic                   clock_i,
   input wire logic                   rst_i,
   input wire logic                   wdt_osc_tick_i,
   input wire logic [`SCP_ADDR_W-1:0] addr_i,
   input wire logic [7:0]             wdata_i,
   input wire logic                   write_i,
   input wire logic                   read_i,
   input wire logic [7:0]             rdata_o,
   input wire logic [6:0]             osc_trim_o,
   input wire logic                   cpu_clk_en_o,
   input wire logic                   io_clk_en_o,
   input wire logic                   adc_clk_en_o,
   input wire logic                   flash_clk_en_o,
   input wire logic                   wdt_clk_en_o,
   input wire logic                   running_o
);
   // History of unlock key writes; bit j is the write taken j+1 edges ago.
   logic [4:0] key_q;
   always_ff @(posedge clock_i) begin
      if (rst_i) key_q <= 5'h00;
      else key_q <= {key_q[3:0], write_i && addr_i == `SCP_OFF_PRESCALE
                                 && wdata_i == `SCP_UNLOCK_WORD};
   end
   default clocking @(posedge clock_i); endclocking
   default disable iff (rst_i);
   a_enables_alike: assert property (cpu_clk_en_o == io_clk_en_o && io_clk_en_o == adc_clk_en_o
      && adc_clk_en_o == flash_clk_en_o) else $error("divided enables differ");
   a_stopped_quiet: assert property (!running_o && !$past(running_o) |-> !cpu_clk_en_o)
      else $error("enable pulse while stopped");
   a_reset_quiet: assert property ($past(rst_i) |-> !running_o && !cpu_clk_en_o && rdata_o == 8'h00)
      else $error("activity right after reset");
   a_wdt_follow: assert property (!$past(rst_i) |-> wdt_clk_en_o == $past(wdt_osc_tick_i))
      else $error("watchdog enable does not follow its tick");
   a_rdata_idle: assert property (!$past(read_i) |-> rdata_o == 8'h00)
      else $error("read data outside read slot");
   a_trim_read: assert property ($past(read_i) && $past(addr_i) == `SCP_OFF_TRIM
      |-> rdata_o == {1'b0, osc_trim_o}) else $error("trim readback wrong");
   a_prescale_gap: assert property ($past(read_i) && $past(addr_i) == `SCP_OFF_PRESCALE
      |-> rdata_o[6:4] == 3'h0) else $error("prescale reserved bits set");
   a_unlock_needs_key: assert property ($past(read_i) && $past(addr_i) == `SCP_OFF_PRESCALE
      && rdata_o[7] |-> |key_q[4:1]) else $error("unlock seen without recent key");
   a_wake_hold: assert property ($fell(running_o) |-> (!running_o)[*6])
      else $error("restart faster than wake delay");
   c_fast_pulses: cover property (cpu_clk_en_o ##2 cpu_clk_en_o);
   c_sleep: cover property ($fell(running_o));
   c_unlock_read: cover property ($past(read_i) && rdata_o[7]);
endmodule
bind scp_top scp_top_sva #(.DELAY_SHORT_WDT(DELAY_SHORT_WDT), .DELAY_LONG_WDT(DELAY_LONG_WDT))
   scp_top_sva_i (.clock_i(clock_i), .rst_i(rst_i), .wdt_osc_tick_i(wdt_osc_tick_i),
   .addr_i(addr_i), .wdata_i(wdata_i), .write_i(write_i), .read_i(read_i), .rdata_o(rdata_o),
   .osc_trim_o(osc_trim_o), .cpu_clk_en_o(cpu_clk_en_o), .io_clk_en_o(io_clk_en_o),
   .adc_clk_en_o(adc_clk_en_o), .flash_clk_en_o(flash_clk_en_o),
   .wdt_clk_en_o(wdt_clk_en_o), .running_o(running_o));

// ---- verif/scp_top_bench.sv ----
// Self-checking bench for the clock control block.
`timescale 1ns/1ps
module scp_top_bench;
   localparam logic [6:0] TF = 7'h2a;
   localparam logic [6:0] TS = 7'h15;
   logic       clock_i, rst_i, d8_f, rpd_f, lp_t, wdt_t, sleep_i, wake_i, write_i, read_i;
   logic [1:0] src_f, sut_f, addr_i;
   logic [7:0] wdata_i, rdata_o;
   logic       cpu_en, wdt_en, running_o;
   int         mismatches, total_checks, cycles, n, old, nw;

   scp_top #(.DELAY_SHORT_WDT(4), .DELAY_LONG_WDT(8), .TRIM_FAST(TF), .TRIM_SLOW(TS)) scp_top_i (
      .clock_i(clock_i), .rst_i(rst_i), .clock_source_select_fuse_i(src_f),
      .startup_time_fuse_i(sut_f), .divide_by_eight_fuse_i(d8_f),
      .reset_pin_disable_fuse_i(rpd_f), .lp_osc_tick_i(lp_t), .wdt_osc_tick_i(wdt_t),
      .sleep_i(sleep_i), .wake_i(wake_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .write_i(write_i), .read_i(read_i), .rdata_o(rdata_o), .osc_trim_o(),
      .cpu_clk_en_o(cpu_en), .io_clk_en_o(), .adc_clk_en_o(), .flash_clk_en_o(),
      .wdt_clk_en_o(wdt_en), .running_o(running_o));

   initial begin
      clock_i = 1'b0;
      forever #12.5 clock_i = ~clock_i;
   end
   // Oscillator ticks: watchdog every 4 cycles, low-power source every 3.
   always @(posedge clock_i) begin
      wdt_t <= (cycles % 4 == 0);
      lp_t <= (cycles % 3 == 0);
      cycles++;
      if (cycles == 60000) begin
         mismatches++;
         print_verdict();
      end
   end

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic chk_rng(input int got, input int lo, input int hi, input string what);
      total_checks++;
      if (got < lo || got > hi) begin
         mismatches++;
         $display("mismatch at %0t: %s count %0d not in %0d..%0d", $time, what, got, lo, hi);
      end
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clock_i);
      write_i <= 1'b1; addr_i <= a; wdata_i <= d;
      @(posedge clock_i);
      write_i <= 1'b0;
   endtask
   task automatic rdc(input logic [1:0] a, input logic [7:0] exp, input string what);
      @(posedge clock_i);
      read_i <= 1'b1; addr_i <= a;
      @(posedge clock_i);
      read_i <= 1'b0;
      #1 chk(rdata_o, exp, what);
   endtask
   // Counts cycles until a level is seen, with a ceiling against hangs.
   task automatic wait_for(input bit want_run, output int c);
      c = 0;
      while ((want_run ? running_o : cpu_en) !== 1'b1 && c < 600) begin
         @(posedge clock_i);
         #1 c++;
      end
   endtask
   task automatic start(input logic [1:0] s, input logic [1:0] t, input logic d, input logic r);
      @(posedge clock_i);
      rst_i <= 1'b1; src_f <= s; sut_f <= t; d8_f <= d; rpd_f <= r;
      repeat (6) @(posedge clock_i);
      rst_i <= 1'b0;
      wait_for(1, n);
      // Fuses move after reset; the latched selection must not follow them.
      src_f <= ~s; sut_f <= ~t; d8_f <= ~d;
   endtask
   task automatic period(output int c);
      wait_for(0, c);
      c = 0;
      do begin
         @(posedge clock_i);
         #1 c++;
      end while (cpu_en !== 1'b1 && c < 600);
   endtask

   initial begin
      rst_i = 1'b1; src_f = 2'h2; sut_f = 2'h2; d8_f = 1'b0; rpd_f = 1'b1; lp_t = 1'b0;
      wdt_t = 1'b0; sleep_i = 1'b0; wake_i = 1'b0; write_i = 1'b0; read_i = 1'b0;
      addr_i = 2'h0; wdata_i = 8'h00;
      start(2'h2, 2'h2, 1'b0, 1'b1);
      chk_rng(n, 42, 54, "delivered start-up");
      rdc(2'h1, 8'h03, "prescale reset");
      rdc(2'h0, {1'b0, TF}, "fast trim");
      period(n);
      chk_rng(n, 8, 8, "divide by eight");
      wr(2'h0, 8'h4a);
      wr(2'h0, 8'h6a);
      wr(2'h0, 8'hff);
      rdc(2'h0, 8'h7f, "trim top bit");
      rdc(2'h3, 8'h00, "unmapped read");
      wr(2'h3, 8'h55);
      rdc(2'h0, 8'h7f, "unmapped write");
      wr(2'h1, 8'h81);
      rdc(2'h1, 8'h03, "dirty key");
      wr(2'h1, 8'h01);
      rdc(2'h1, 8'h03, "keyless write");
      wr(2'h1, 8'h80);
      rdc(2'h1, 8'h83, "key visible");
      repeat (4) @(posedge clock_i);
      rdc(2'h1, 8'h03, "key expired");
      wr(2'h1, 8'h02);
      rdc(2'h1, 8'h03, "late write");
      wr(2'h1, 8'h80);
      wr(2'h1, 8'h80);
      @(posedge clock_i);
      wr(2'h1, 8'h01);
      rdc(2'h1, 8'h03, "key not restarted");
      old = 8;
      for (int c = 0; c < 10; c++) begin
         nw = 1 << (c > 8 ? 8 : c);
         wr(2'h1, 8'h80);
         wr(2'h1, c[7:0]);
         rdc(2'h1, c[7:0], "division readback");
         for (int j = 0; j < 4; j++) begin
            period(n);
            if (j < 3) chk_rng(n, old < nw ? old : nw, 2 * (old > nw ? old : nw), "switch");
            else chk_rng(n, nw, nw, "division factor");
         end
         rdc(2'h2, {4'h1, (c > 8 ? 4'h8 : c[3:0])}, "status");
         old = nw;
      end
      @(posedge clock_i);
      sleep_i <= 1'b1;
      @(posedge clock_i);
      sleep_i <= 1'b0;
      repeat (4) @(posedge clock_i);
      #1 chk(running_o, 1'b0, "sleep");
      @(posedge clock_i);
      wake_i <= 1'b1;
      @(posedge clock_i);
      wake_i <= 1'b0;
      wait_for(1, n);
      chk_rng(n, 6, 9, "wake delay");
      start(2'h1, 2'h0, 1'b1, 1'b1);
      chk_rng(n, 28, 40, "slow start-up");
      rdc(2'h0, {1'b0, TS}, "slow trim");
      rdc(2'h1, 8'h00, "undivided reset");
      period(n);
      chk_rng(n, 2, 2, "slow mode halves");
      start(2'h2, 2'h0, 1'b1, 1'b1);
      chk_rng(n, 14, 20, "short start-up");
      start(2'h2, 2'h1, 1'b1, 1'b1);
      chk_rng(n, 26, 38, "medium start-up");
      start(2'h2, 2'h0, 1'b1, 1'b0);
      chk_rng(n, 26, 38, "pin fuse stretch");
      start(2'h3, 2'h0, 1'b1, 1'b1);
      chk_rng(n, 39, 50, "low-power start-up");
      nw = 0;
      repeat (30) begin
         @(posedge clock_i);
         #1 nw += (cpu_en === 1'b1);
      end
      chk_rng(nw, 10, 10, "low-power pulses");
      print_verdict();
   end
endmodule
